// ===== ircm_cfg.svh
/*
  Offsets, field positions and reset values of the remote waveform block.
  Assumes it is included by its bare name from the package and the top.
*/
`ifndef IRCM_CFG_SVH
`define IRCM_CFG_SVH

// Register byte offsets, one aligned 32-bit word each.
`define IRCM_OFS_HALT        12'h000
`define IRCM_OFS_GO          12'h004
`define IRCM_OFS_RUN         12'h008
`define IRCM_OFS_GATE        12'h00c
`define IRCM_OFS_LEVEL       12'h010
`define IRCM_OFS_POLARITY    12'h014
`define IRCM_OFS_MODE        12'h018
`define IRCM_OFS_SELECT      12'h01c
`define IRCM_OFS_MASK_PER    12'h020
`define IRCM_OFS_MASK_HIGH   12'h024
`define IRCM_OFS_CARR_PER    12'h028
`define IRCM_OFS_CARR_HIGH   12'h02c
`define IRCM_OFS_IRQ_FLAG    12'h030
`define IRCM_OFS_IRQ_MASK    12'h034

// Channel bits that exist in the 16-bit channel registers, then other field positions.
`define IRCM_CH_BITS         16'h003c
`define IRCM_CH3_UPPER_BIT   11
`define IRCM_RUN_BITS        16'h083c
`define IRCM_CH3_BYTE_BIT    3
`define IRCM_REMOTE_SEL_BIT  0
`define IRCM_IRQ_MASK_CYCLE  0
`define IRCM_IRQ_CH3_END     1
`define IRCM_IRQ_W           2

// Reset values.
`define IRCM_RST_WORD        16'h0000
`define IRCM_RST_BYTE        8'h00
`define IRCM_RST_IRQ         2'h0

// Clock rate of pclk; the channel count clock is pclk itself.
`define IRCM_PCLK_HZ         10000000

`endif

// ===== ircm_pkg.sv
/*
  Types shared by the remote waveform block.
  Assumes ircm_cfg.svh is on the include path.
*/
package ircm_pkg;
  `include "ircm_cfg.svh"

  typedef logic [15:0] ircm_word_t;
  typedef logic [7:0]  ircm_byte_t;
  typedef logic [`IRCM_IRQ_W-1:0] ircm_irq_t;
endpackage

// ===== ircm_pair_if.sv
/*
  Signals between the top and one master/slave counter pair.
  Assumes a single clock shared by both ends.
*/
interface ircm_pair_if;
  logic [15:0] period;
  logic [15:0] high;
  logic        m_run;
  logic        s_run;
  logic        m_pulse;
  logic        s_set;
  logic        s_clr;
  logic        s_end;

  modport top  (output period, output high, output m_run, output s_run,
                input m_pulse, input s_set, input s_clr, input s_end);
  modport pair (input period, input high, input m_run, input s_run,
                output m_pulse, output s_set, output s_clr, output s_end);
endinterface

// ===== ircm_pair.sv
/*
  One master period counter and one slave one-shot counter.
  Assumes period and high are stable while the pair counts.
*/
module ircm_pair
  import ircm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  ircm_pair_if.pair p
);
  ircm_word_t m_cnt_reg;
  ircm_word_t s_cnt_reg;
  logic       m_run_d_reg;
  logic       m_pulse_reg;
  logic       s_end_reg;
  logic       started;
  logic       m_wrap;
  logic       s_last;

  // A start gives an immediate period pulse, then one every period+1 ticks.
  assign started = p.m_run & ~m_run_d_reg;
  assign m_wrap  = p.m_run & m_run_d_reg & (m_cnt_reg == 16'h0000);
  // Expiry is seen one tick before the count empties so the clear lands
  // exactly high ticks after the set; a reload on the same edge wins.
  assign s_last  = p.s_run & (s_cnt_reg == 16'h0001) & ~m_pulse_reg;

  // Master counts down from the period value and reloads at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_cnt_reg   <= 16'h0000;
      m_run_d_reg <= 1'b0;
      m_pulse_reg <= 1'b0;
    end else begin
      m_run_d_reg <= p.m_run;
      m_pulse_reg <= started | m_wrap;
      if (started || m_wrap)
        m_cnt_reg <= p.period;
      else if (p.m_run)
        m_cnt_reg <= m_cnt_reg - 16'h0001;
    end
  end

  // Slave loads its high count on each master pulse; a high count beyond
  // the period is reloaded before it expires, so the output stays high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_cnt_reg <= 16'h0000;
      s_end_reg <= 1'b0;
    end else begin
      s_end_reg <= s_last;
      if (p.s_run && m_pulse_reg)
        s_cnt_reg <= p.high;
      else if (p.s_run && s_cnt_reg != 16'h0000)
        s_cnt_reg <= s_cnt_reg - 16'h0001;
    end
  end

  // Set by the master pulse, reset by the slave's own expiry.
  assign p.m_pulse = m_pulse_reg;
  assign p.s_set   = p.s_run & m_pulse_reg & (p.high != 16'h0000);
  assign p.s_clr   = (p.s_run & m_pulse_reg & (p.high == 16'h0000))
                   | s_last;
  assign p.s_end   = s_end_reg;
endmodule

// ===== ircm_top.sv
/*
  Remote waveform generator: APB register file, four timer channels in two
  master/slave pairs, output level logic, remote pin and interrupt.
  Assumes a single pclk domain, an APB3 master and synchronous inputs.
*/
// Behaviour
// - Halt bit one stops channel; zero ignored.
// - Byte mode: channel 3 halt stops lower only.
// - Gate low: output holds, software level writes.
// - Gate high: timer drives level, writes ignored.
// - Level bit zero low, one high.
// - Select routes waveform; else plain timer outputs.
// - Carrier period is value plus one ticks.
// - Carrier high time equals value ticks.
// - Mask period is value plus one ticks.
// - Mask high time equals value ticks.
// - High above period keeps mask high.
// - Mask cycle sets flag; software clears with zero.
// - Go bit one sets running flag.
// - Slave set by master, reset by itself.
// - Polarity bit selects high or low active.

// Offsets and field positions; the guard makes a second inclusion harmless.
`include "ircm_cfg.svh"

module ircm_top
  import ircm_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [3:0]        timer_out,
  output logic                   remote_waveform_pin,
  output logic                   irq
);
  ircm_word_t run_reg;
  ircm_word_t run_next;
  ircm_word_t gate_reg;
  ircm_word_t level_reg;
  ircm_word_t level_next;
  ircm_word_t polarity_reg;
  ircm_byte_t mode_reg;
  ircm_byte_t select_reg;
  ircm_word_t mask_per_reg;
  ircm_word_t mask_high_reg;
  ircm_word_t carr_per_reg;
  ircm_word_t carr_high_reg;
  ircm_irq_t  flag_reg;
  ircm_irq_t  flag_next;
  ircm_irq_t  irq_mask_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [3:0]  timer_out_reg;
  logic        remote_reg;
  logic        irq_reg;

  logic [ADDR_W-1:0] addr;
  logic        access;
  logic        first_access;
  logic        done;
  logic        wr;
  logic        hit_halt;
  logic        hit_go;
  logic        hit_run;
  logic        hit_gate;
  logic        hit_level;
  logic        hit_pol;
  logic        hit_mode;
  logic        hit_sel;
  logic        hit_mper;
  logic        hit_mhigh;
  logic        hit_cper;
  logic        hit_chigh;
  logic        hit_flag;
  logic        hit_imask;
  logic        mapped;
  logic [31:0] rd_mux;

  ircm_word_t  halt_bits;
  ircm_word_t  go_bits;
  ircm_word_t  halt_eff;
  ircm_word_t  go_eff;
  logic        ch3_byte_mode;
  ircm_word_t  hw_set;
  ircm_word_t  hw_clr;
  ircm_word_t  hw_tog;
  ircm_word_t  hw_val;
  ircm_word_t  sw_val;
  ircm_word_t  chan_pin;
  logic        remote_sel;
  ircm_irq_t   events;

  logic [1:0]  m_pulse_w;
  logic [1:0]  s_set_w;
  logic [1:0]  s_clr_w;
  logic [1:0]  s_end_w;

  // APB phase decode: one wait state gives time to register the read data.
  assign addr         = paddr;
  assign access       = psel & penable;
  assign first_access = access & ~pready_reg;
  assign done         = access & pready_reg;
  assign wr           = done & pwrite;

  // Address decode, one wire per register.
  assign hit_halt  = (addr == `IRCM_OFS_HALT);
  assign hit_go    = (addr == `IRCM_OFS_GO);
  assign hit_run   = (addr == `IRCM_OFS_RUN);
  assign hit_gate  = (addr == `IRCM_OFS_GATE);
  assign hit_level = (addr == `IRCM_OFS_LEVEL);
  assign hit_pol   = (addr == `IRCM_OFS_POLARITY);
  assign hit_mode  = (addr == `IRCM_OFS_MODE);
  assign hit_sel   = (addr == `IRCM_OFS_SELECT);
  assign hit_mper  = (addr == `IRCM_OFS_MASK_PER);
  assign hit_mhigh = (addr == `IRCM_OFS_MASK_HIGH);
  assign hit_cper  = (addr == `IRCM_OFS_CARR_PER);
  assign hit_chigh = (addr == `IRCM_OFS_CARR_HIGH);
  assign hit_flag  = (addr == `IRCM_OFS_IRQ_FLAG);
  assign hit_imask = (addr == `IRCM_OFS_IRQ_MASK);
  assign mapped    = hit_halt | hit_go | hit_run | hit_gate | hit_level
                   | hit_pol | hit_mode | hit_sel | hit_mper | hit_mhigh
                   | hit_cper | hit_chigh | hit_flag | hit_imask;

  // Read mux; trigger registers are write-only and read as zero.
  assign rd_mux =
      hit_run   ? {16'h0000, run_reg}                          :
      hit_gate  ? {16'h0000, gate_reg}                         :
      hit_level ? {16'h0000, level_reg}                        :
      hit_pol   ? {16'h0000, polarity_reg}                     :
      hit_mode  ? {24'h000000, mode_reg}                       :
      hit_sel   ? {24'h000000, select_reg}                     :
      hit_mper  ? {16'h0000, mask_per_reg}                     :
      hit_mhigh ? {16'h0000, mask_high_reg}                    :
      hit_cper  ? {16'h0000, carr_per_reg}                     :
      hit_chigh ? {16'h0000, carr_high_reg}                    :
      hit_flag  ? {30'h00000000, flag_reg}                     :
      hit_imask ? {30'h00000000, irq_mask_reg}                 :
                  32'h00000000;

  // Bus handshake registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= first_access;
      pslverr_reg <= first_access & ~mapped;
      if (first_access && !pwrite)
        prdata_reg <= rd_mux;
    end
  end

  // Trigger bits: only ones act, zeros cause no trigger at all.
  assign halt_bits     = (wr & hit_halt) ? pwdata[15:0] : 16'h0000;
  assign go_bits       = (wr & hit_go) ? pwdata[15:0] : 16'h0000;
  assign ch3_byte_mode = mode_reg[`IRCM_CH3_BYTE_BIT];

  // In byte mode the channel 3 halt bit reaches only the lower byte timer;
  // in word mode it also stops the upper half so both flags stay in step.
  assign halt_eff = halt_bits
                  | ((!ch3_byte_mode && halt_bits[3])
                     ? 16'h0800 : 16'h0000);
  assign go_eff   = go_bits
                  | ((!ch3_byte_mode && go_bits[3])
                     ? 16'h0800 : 16'h0000);
  assign run_next = ((run_reg | go_eff) & ~halt_eff)
                  & `IRCM_RUN_BITS;

  // Channel running flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      run_reg <= `IRCM_RST_WORD;
    else
      run_reg <= run_next;
  end

  // Plain configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg      <= `IRCM_RST_WORD;
      polarity_reg  <= `IRCM_RST_WORD;
      mode_reg      <= `IRCM_RST_BYTE;
      select_reg    <= `IRCM_RST_BYTE;
      mask_per_reg  <= `IRCM_RST_WORD;
      mask_high_reg <= `IRCM_RST_WORD;
      carr_per_reg  <= `IRCM_RST_WORD;
      carr_high_reg <= `IRCM_RST_WORD;
      irq_mask_reg  <= `IRCM_RST_IRQ;
    end else if (wr) begin
      if (hit_gate)  gate_reg      <= pwdata[15:0] & `IRCM_CH_BITS;
      if (hit_pol)   polarity_reg  <= pwdata[15:0] & `IRCM_CH_BITS;
      if (hit_mode)  mode_reg      <= pwdata[7:0] & 8'h08;
      if (hit_sel)   select_reg    <= pwdata[7:0] & 8'h01;
      if (hit_mper)  mask_per_reg  <= pwdata[15:0];
      if (hit_mhigh) mask_high_reg <= pwdata[15:0];
      if (hit_cper)  carr_per_reg  <= pwdata[15:0];
      if (hit_chigh) carr_high_reg <= pwdata[15:0];
      if (hit_imask) irq_mask_reg  <= pwdata[`IRCM_IRQ_W-1:0];
    end
  end

  // Counter pairs: pair 0 is the mask (channels 2 and 3), pair 1 the
  // carrier (channels 4 and 5).
  for (genvar g = 0; g < 2; g++) begin : g_pair
    ircm_pair_if pif ();

    // The byte-mode slave of the mask pair sees only its lower eight bits.
    if (g == 0) begin : g_mask
      assign pif.period = mask_per_reg;
      assign pif.high   = ch3_byte_mode
                        ? {8'h00, mask_high_reg[7:0]} : mask_high_reg;
    end else begin : g_carr
      assign pif.period = carr_per_reg;
      assign pif.high   = carr_high_reg;
    end
    assign pif.m_run = run_reg[2 + 2 * g];
    assign pif.s_run = run_reg[3 + 2 * g];
    assign m_pulse_w[g] = pif.m_pulse;
    assign s_set_w[g]   = pif.s_set;
    assign s_clr_w[g]   = pif.s_clr;
    assign s_end_w[g]   = pif.s_end;

    ircm_pair u_pair (
      .pclk    (pclk),
      .presetn (presetn),
      .p       (pif.pair)
    );
  end

  // Timer events per channel bit: masters toggle, slaves are set and reset.
  assign hw_tog = {10'h000, 1'b0, m_pulse_w[1], 1'b0, m_pulse_w[0], 2'b00};
  assign hw_set = {10'h000, s_set_w[1], 1'b0, s_set_w[0], 1'b0, 2'b00};
  assign hw_clr = {10'h000, s_clr_w[1], 1'b0, s_clr_w[0], 1'b0, 2'b00};

  // A gated bit follows the timer and ignores software; an ungated bit
  // holds and takes software writes.
  assign hw_val = ((level_reg | hw_set) & ~hw_clr) ^ hw_tog;
  assign sw_val = (wr & hit_level) ? pwdata[15:0] : level_reg;
  assign level_next = ((gate_reg & hw_val) | (~gate_reg & sw_val))
                    & `IRCM_CH_BITS;

  // Output level bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      level_reg <= `IRCM_RST_WORD;
    else
      level_reg <= level_next;
  end

  // Pin levels: the level bit, inverted where the channel is low active.
  assign chan_pin   = level_reg ^ polarity_reg;
  assign remote_sel = select_reg[`IRCM_REMOTE_SEL_BIT];

  // Pins are registered so no decode glitch reaches the emitter driver.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_reg <= 4'h0;
      remote_reg    <= 1'b0;
    end else begin
      timer_out_reg <= remote_sel ? 4'h0 : chan_pin[5:2];
      remote_reg    <= remote_sel & chan_pin[3] & chan_pin[5];
    end
  end

  // Interrupt flags: set wins over a clear in the same cycle, and a flag
  // is cleared by writing a zero to its bit.
  assign events    = {s_end_w[0], m_pulse_w[0]};
  assign flag_next = ((wr & hit_flag)
                      ? (flag_reg & pwdata[`IRCM_IRQ_W-1:0])
                      : flag_reg) | events;

  // Flags and the level interrupt output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= `IRCM_RST_IRQ;
      irq_reg  <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      irq_reg  <= |(flag_next & irq_mask_reg);
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign timer_out           = timer_out_reg;
  assign remote_waveform_pin = remote_reg;
  assign irq                 = irq_reg;
endmodule

// ===== ircm_top_chk.sv
/*
  Concurrent checks on the ports of ircm_top.
  Assumes a single pclk domain and the bind statement at the foot.
*/
module ircm_top_chk
  import ircm_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [3:0]        timer_out,
  input wire logic              remote_waveform_pin,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ns;

  // One domain, so the clock and the reset are named once.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // An access phase opens, and the answer comes after one wait state.
  sequence acc_start;
    psel && $rose(penable);
  endsequence
  sequence one_wait;
    !pready ##1 pready;
  endsequence

  // Bus answers: timing, a single pulse, errors and trigger reads.
  ready_wait_a: assert property (acc_start |-> one_wait)
    else $error("pready not one cycle after access start");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  trig_read_a: assert property (
    pready && !pwrite && paddr[ADDR_W-1:3] == '0 |-> prdata == 32'h0)
    else $error("trigger register read not zero");

  // The remote pin and the plain channel outputs never run together; irq, the remote pin and the channel outputs are quiet after reset.
  remote_excl_a: assert property (
    remote_waveform_pin |-> timer_out == 4'h0)
    else $error("channel outputs active while remote pin used");
  reset_quiet_a: assert property (
    $rose(presetn) |-> !irq && !remote_waveform_pin && timer_out == 4'h0)
    else $error("outputs not quiet after reset");
endmodule

bind ircm_top ircm_top_chk #(.ADDR_W(ADDR_W)) chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .timer_out(timer_out),
  .remote_waveform_pin(remote_waveform_pin),
  .irq(irq)
);

// ===== ircm_emitter.sv
/*
  Model of the infrared emitter on the remote pin.
  Assumes the pin is sampled on pclk and the bench clears the count.
*/
module ircm_emitter (
  input wire logic pclk,
  input wire logic clr,
  input wire logic led,
  output int       lit_cycles
);
  timeunit 1ns;
  timeprecision 1ns;

  // Counts lit cycles; a window count hides the phase of the waveform.
  always @(posedge pclk) begin
    if (clr)
      lit_cycles <= 0;
    else if (led)
      lit_cycles <= lit_cycles + 1;
  end
endmodule

// ===== test_ir_remote_carrier_mask_output.sv
/*
  Self-checking bench for ircm_top: APB master, register model, waveform
  measurements. Assumes ircm_top_chk and ircm_emitter are compiled too.
*/
module test_ir_remote_carrier_mask_output
  import ircm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  timer_out;
  logic        pready, pslverr, remote_waveform_pin, irq, err, emit_clr = 0;
  logic [31:0] seed = 32'h0001_5084;
  int          mismatches = 0, tests_run = 0, lit_cycles, hi, per, c;
  int          mdl[16] = '{default: 0};
  int          msk[14] = '{0, 0, 0, 'h3c, 'h3c, 'h3c, 8, 1, 'hffff, 'hffff,
                           'hffff, 'hffff, 3, 3};

  ircm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_out(timer_out), .remote_waveform_pin(remote_waveform_pin),
    .irq(irq));
  ircm_emitter emit_u (.pclk(pclk), .clr(emit_clr),
    .led(remote_waveform_pin), .lit_cycles(lit_cycles));

  // Free-running 10 MHz clock.
  initial forever #50 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // One APB transfer; the extra edge keeps two transfers from colliding.
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Write that also updates the register model.
  task automatic wr(input logic [11:0] a, input int d);
    int i;
    i = a >> 2;
    apb(1'b1, a, d);
    if (i < 2) begin
      d = (d & 'h83c) | ((d & 8) != 0 && mdl[6] == 0 ? 'h800 : 0);
      mdl[2] = i ? (mdl[2] | d) : (mdl[2] & ~d);
    end else if (i == 4)
      mdl[4] = (mdl[4] & mdl[3]) | (d & 'h3c & ~mdl[3]);
    else if (i > 2 && i < 14 && i != 12)
      mdl[i] = d & msk[i];
  endtask

  task automatic rdm(input logic [11:0] a);
    apb(1'b0, a, 0);
    check(rd, mdl[a >> 2]);
  endtask

  task automatic wait_lvl(input int b, input logic v, output int n);
    n = 0;
    while (timer_out[b] !== v) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // High time and full period of one output, from rise to rise.
  task automatic meas(input int b);
    wait_lvl(b, 1'b0, c);
    wait_lvl(b, 1'b1, c);
    wait_lvl(b, 1'b0, hi);
    wait_lvl(b, 1'b1, per);
    per += hi;
  endtask

  task automatic halt_all();
    wr(12'h000, 'h3c);
    wr(12'h00c, 0);
    wr(12'h010, 0);
  endtask

  task automatic stop_test();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 14; i++)
      rdm(12'(i * 4));
    for (int i = 8; i < 12; i++) begin
      wr(12'(i * 4), xs() & 'hffff);
      rdm(12'(i * 4));
    end
    apb(1'b1, 12'h038, 'hffff);
    apb(1'b0, 12'h038, 0);
    check(rd, 0);
    check(err, 1'b1);
    $display("done: registers");
    wr(12'h010, 'h3c);
    repeat (2) @(posedge pclk);
    check(timer_out, 4'hf);
    wr(12'h014, 'h14);
    repeat (2) @(posedge pclk);
    check(timer_out, 4'ha);
    wr(12'h014, 0);
    wr(12'h00c, 'h3c);
    wr(12'h010, 0);
    rdm(12'h010);
    check(timer_out, 4'hf);
    halt_all();
    repeat (2) @(posedge pclk);
    check(timer_out, 4'h0);
    $display("done: levels");
    wr(12'h028, 199);
    wr(12'h02c, 60);
    wr(12'h00c, 'h30);
    wr(12'h004, 'h30);
    rdm(12'h008);
    meas(3);
    check(hi, 60);
    check(per, 200);
    wr(12'h000, 'h30);
    rdm(12'h008);
    rd[3:0] = timer_out;
    repeat (250) @(posedge pclk);
    check(timer_out, rd[3:0]);
    halt_all();
    $display("done: carrier");
    wr(12'h034, 1);
    wr(12'h020, 4399);
    wr(12'h024, 2950);
    wr(12'h00c, 'h0c);
    wr(12'h004, 'h0c);
    rdm(12'h008);
    meas(1);
    check(hi, 2950);
    check(per, 4400);
    check(irq, 1'b1);
    apb(1'b0, 12'h030, 0);
    check(rd[0], 1'b1);
    wr(12'h030, 0);
    apb(1'b0, 12'h030, 0);
    check(rd[0], 1'b0);
    check(irq, 1'b0);
    wr(12'h034, 0);
    wait_lvl(1, 1'b0, c);
    wait_lvl(1, 1'b1, c);
    repeat (3) @(posedge pclk);
    check(irq, 1'b0);
    apb(1'b0, 12'h030, 0);
    check(rd[0], 1'b1);
    wr(12'h034, 1);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1);
    $display("done: mask and interrupt");
    wr(12'h000, 'h0c);
    wr(12'h024, 4400);
    wr(12'h004, 'h0c);
    repeat (10) @(posedge pclk);
    // Every tick is looked at, so a one-tick dip at the reload is caught.
    for (int i = 0; i < 9; i++) begin
      c = 0;
      repeat (1000) begin
        @(posedge pclk);
        if (timer_out[1] !== 1'b1) c++;
      end
      check(c, 0);
    end
    halt_all();
    wr(12'h018, 8);
    wr(12'h004, 'h808);
    rdm(12'h008);
    wr(12'h000, 8);
    rdm(12'h008);
    wr(12'h000, 'h800);
    wr(12'h018, 0);
    $display("done: full mask and byte mode");
    wr(12'h028, 9);
    wr(12'h02c, 3);
    wr(12'h020, 59);
    wr(12'h024, 30);
    wr(12'h00c, 'h3c);
    wr(12'h01c, 1);
    wr(12'h004, 'h3c);
    repeat (20) @(posedge pclk);
    emit_clr <= 1'b1;
    @(posedge pclk);
    emit_clr <= 1'b0;
    repeat (121) @(posedge pclk);
    check(lit_cycles, 18);
    check(timer_out, 4'h0);
    halt_all();
    $display("done: remote pin");
    stop_test();
  end

  // Cuts a hang short; the planned run needs well under 40000 cycles.
  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
endmodule
